// file: rtl/pcl_consts.svh
// Purpose: named constants for the codec serial link
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef PCL_CONSTS_SVH
`define PCL_CONSTS_SVH

`define PCL_WORD_BITS 16
`define PCL_LIN_BITS 13
`define PCL_VOL_BITS 3
`define PCL_MU_BITS 8
`define PCL_CNT_BITS 5
`define PCL_LAST_BIT 5'h10
`define PCL_LINK_CLK_KHZ 2048
`define PCL_FRAME_KHZ 8
`define PCL_BITS_PER_FRAME (`PCL_LINK_CLK_KHZ / `PCL_FRAME_KHZ)
`define PCL_LIN_PAD 3'h0
`define PCL_MU_PAD 8'h00
`define PCL_WORD_RST 16'h0000
`define PCL_VOL_RST 3'h0

`endif

// file: rtl/pcl_pkg.sv
// Purpose: shared types of the codec serial link
// Assumes: nothing beyond the constants header
// Notes: link shifter states and sample formats
package pcl_pkg;
  typedef enum logic [0:0] {
    PCL_IDLE = 1'b0,
    PCL_SHIFT = 1'b1
  } pcl_state_t;

  typedef enum logic [0:0] {
    PCL_FMT_MULAW = 1'b0,
    PCL_FMT_LINEAR = 1'b1
  } pcl_fmt_t;
endpackage : pcl_pkg

// file: rtl/pcl_skid_buffer.sv
// Purpose: two-entry valid/ready buffer on the playback path
// Assumes: one clock, asynchronous active-high reset
// Notes: full and empty are exact; data comes from flops
`timescale 1ns/10ps
`default_nettype none
module pcl_skid_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  generate
    if (DEPTH != 2 || WIDTH < 1)
    begin : g_chk
      $error("pcl_skid_buffer serves only DEPTH 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_in_ready = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = i_in_data;
      wr_d = ~wr_q;
    end
    if (pop)
      rd_d = ~rd_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mem_q <= '{default: '0};
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : pcl_skid_buffer
`default_nettype wire

// file: rtl/pcl_codec_link.sv
// Purpose: serial PCM port of a slave voice codec
// Assumes: link clock and frame sync come from the external master
// Notes: 16-bit words, msb first, one word per frame
`timescale 1ns/10ps
`default_nettype none
`include "pcl_consts.svh"
module pcl_codec_link (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_codec_frame_sync_in,
  input wire logic i_codec_serial_data_in,
  output logic o_codec_serial_data_out,
  output logic o_codec_serial_data_out_oe_n,
  input wire logic i_linear_mode,
  input wire logic i_adc_valid,
  output logic o_adc_ready,
  input wire logic [`PCL_LIN_BITS-1:0] i_adc_sample,
  output logic o_play_valid,
  input wire logic i_play_ready,
  output logic [`PCL_WORD_BITS-1:0] o_play_word,
  output logic [`PCL_VOL_BITS-1:0] o_play_volume,
  output logic o_play_overrun
);
  import pcl_pkg::*;

  function automatic logic [`PCL_WORD_BITS-1:0] fmt_tx(
    input logic lin,
    input logic [`PCL_LIN_BITS-1:0] s
  );
    if (lin)
      fmt_tx = {s, `PCL_LIN_PAD};
    else
      fmt_tx = {s[`PCL_MU_BITS-1:0], `PCL_MU_PAD};
  endfunction : fmt_tx

  // sys domain: mode sync, sample hand-off toward the link
  logic mode_s1_q, mode_s2_q;
  logic [`PCL_WORD_BITS-1:0] tx_hold_q, tx_hold_d;
  logic tx_tgl_q, tx_tgl_d;
  logic ack_s1_q, ack_s2_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  logic [`PCL_VOL_BITS-1:0] vol_q, vol_d;
  logic ovr_q, ovr_d;
  logic buf_in_ready, buf_in_valid;
  logic [`PCL_WORD_BITS:0] buf_out;

  // link domain state
  logic lrst_s1_q, lrst_q;
  logic lmode_s1_q, lmode_q;
  logic ltx_s1_q, ltx_s2_q, ltx_ack_q, ltx_ack_d;
  logic [`PCL_WORD_BITS-1:0] ltx_cur_q, ltx_cur_d;
  pcl_state_t st_q, st_d;
  logic [`PCL_CNT_BITS-1:0] cnt_q, cnt_d;
  logic [`PCL_WORD_BITS-1:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic dout_q, dout_d, oe_n_q, oe_n_d;
  logic [`PCL_WORD_BITS:0] rx_word_q, rx_word_d;
  logic rx_tgl_q, rx_tgl_d;

  // a new sample is only taken once the link acknowledged the last one,
  // so tx_hold_q is stable whenever the link domain samples it
  assign o_adc_ready = (tx_tgl_q == ack_s2_q);

  always_comb
  begin
    tx_hold_d = tx_hold_q;
    tx_tgl_d = tx_tgl_q;
    ovr_d = 1'b0;
    vol_d = vol_q;
    buf_in_valid = (rx_s2_q != rx_s3_q);
    if (i_adc_valid && o_adc_ready)
    begin
      tx_hold_d = fmt_tx(mode_s2_q, i_adc_sample);
      tx_tgl_d = ~tx_tgl_q;
    end
    if (buf_in_valid && !buf_in_ready)
      ovr_d = 1'b1;
    if (o_play_valid && i_play_ready && buf_out[`PCL_WORD_BITS])
      vol_d = buf_out[`PCL_VOL_BITS-1:0];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      tx_hold_q <= `PCL_WORD_RST;
      tx_tgl_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      vol_q <= `PCL_VOL_RST;
      ovr_q <= 1'b0;
    end
    else
    begin
      mode_s1_q <= i_linear_mode;
      mode_s2_q <= mode_s1_q;
      tx_hold_q <= tx_hold_d;
      tx_tgl_q <= tx_tgl_d;
      ack_s1_q <= ltx_ack_q;
      ack_s2_q <= ack_s1_q;
      rx_s1_q <= rx_tgl_q;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      vol_q <= vol_d;
      ovr_q <= ovr_d;
    end
  end

  // receiver stalls back up here; a word that finds the buffer full
  // is reported as an overrun
  pcl_skid_buffer #(
    .WIDTH(`PCL_WORD_BITS + 1),
    .DEPTH(2)
  ) u_play_buf (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(buf_in_valid),
    .o_in_ready(buf_in_ready),
    .i_in_data(rx_word_q),
    .o_out_valid(o_play_valid),
    .i_out_ready(i_play_ready),
    .o_out_data(buf_out)
  );

  assign o_play_word = buf_out[`PCL_WORD_BITS-1:0];
  assign o_play_volume = vol_q;
  assign o_play_overrun = ovr_q;

  // link domain reset: asserted at once, released on a link edge
  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lrst_s1_q <= 1'b1;
      lrst_q <= 1'b1;
    end
    else
    begin
      lrst_s1_q <= 1'b0;
      lrst_q <= lrst_s1_q;
    end
  end

  // all link logic on the master clock
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    tsh_d = tsh_q;
    rsh_d = rsh_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    rx_word_d = rx_word_q;
    rx_tgl_d = rx_tgl_q;
    ltx_cur_d = ltx_cur_q;
    ltx_ack_d = ltx_ack_q;
    if (ltx_s2_q != ltx_ack_q)
    begin
      ltx_cur_d = tx_hold_q;
      ltx_ack_d = ltx_s2_q;
    end
    // word timing taken from the master's sync
    if (i_codec_frame_sync_in)
    begin
      // sync starts a 16-bit word, msb first
      st_d = PCL_SHIFT;
      cnt_d = `PCL_CNT_BITS'(1);
      dout_d = ltx_cur_q[`PCL_WORD_BITS-1];
      tsh_d = {ltx_cur_q[`PCL_WORD_BITS-2:0], 1'b0};
      rsh_d = {rsh_q[`PCL_WORD_BITS-2:0], i_codec_serial_data_in};
      oe_n_d = 1'b0;
    end
    else
    begin
      case (st_q)
        PCL_IDLE:
          oe_n_d = 1'b1;
        PCL_SHIFT:
        begin
          if (cnt_q == `PCL_LAST_BIT)
          begin
            st_d = PCL_IDLE;
            oe_n_d = 1'b1;
          end
          else
          begin
            // shift out sample, shift in playback
            dout_d = tsh_q[`PCL_WORD_BITS-1];
            tsh_d = {tsh_q[`PCL_WORD_BITS-2:0], 1'b0};
            rsh_d = {rsh_q[`PCL_WORD_BITS-2:0], i_codec_serial_data_in};
            cnt_d = cnt_q + `PCL_CNT_BITS'(1);
            if (cnt_q == `PCL_LAST_BIT - `PCL_CNT_BITS'(1))
            begin
              rx_word_d = {lmode_q, rsh_q[`PCL_WORD_BITS-2:0],
                           i_codec_serial_data_in};
              rx_tgl_d = ~rx_tgl_q;
            end
          end
        end
        default:
        begin
          st_d = PCL_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lmode_s1_q <= 1'b0;
      lmode_q <= 1'b0;
      ltx_s1_q <= 1'b0;
      ltx_s2_q <= 1'b0;
      ltx_ack_q <= 1'b0;
      ltx_cur_q <= `PCL_WORD_RST;
      st_q <= PCL_IDLE;
      cnt_q <= '0;
      tsh_q <= `PCL_WORD_RST;
      rsh_q <= `PCL_WORD_RST;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
      rx_word_q <= '0;
      rx_tgl_q <= 1'b0;
    end
    else
    begin
      lmode_s1_q <= i_linear_mode;
      lmode_q <= lmode_s1_q;
      ltx_s1_q <= tx_tgl_q;
      ltx_s2_q <= ltx_s1_q;
      if (lrst_q)
      begin
        st_q <= PCL_IDLE;
        oe_n_q <= 1'b1;
      end
      else
      begin
        ltx_ack_q <= ltx_ack_d;
        ltx_cur_q <= ltx_cur_d;
        st_q <= st_d;
        cnt_q <= cnt_d;
        tsh_q <= tsh_d;
        rsh_q <= rsh_d;
        dout_q <= dout_d;
        oe_n_q <= oe_n_d;
        rx_word_q <= rx_word_d;
        rx_tgl_q <= rx_tgl_d;
      end
    end
  end

  assign o_codec_serial_data_out = dout_q;
  assign o_codec_serial_data_out_oe_n = oe_n_q;
endmodule : pcl_codec_link
`default_nettype wire

// file: testbench/pcl_link_checker.sv
// Purpose: port checks of the codec link
// Assumes: bound to pcl_codec_link
// Notes: link and system domains apart
`timescale 1ns/10ps
`default_nettype none
`include "pcl_consts.svh"
module pcl_link_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_codec_frame_sync_in,
  input wire logic o_codec_serial_data_out_oe_n,
  input wire logic i_adc_valid,
  input wire logic o_adc_ready,
  input wire logic o_play_valid,
  input wire logic i_play_ready,
  input wire logic [`PCL_WORD_BITS-1:0] o_play_word,
  input wire logic [`PCL_VOL_BITS-1:0] o_play_volume,
  input wire logic o_play_overrun
);
  logic pop_q;
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst) pop_q <= 1'h0;
    else pop_q <= o_play_valid & i_play_ready;
  sequence s_quiet16;
    (!i_codec_frame_sync_in)[*8] ##1
    (!i_codec_frame_sync_in)[*8];
  endsequence
  sequence s_drive16;
    (!o_codec_serial_data_out_oe_n)[*8] ##1
    (!o_codec_serial_data_out_oe_n)[*8];
  endsequence
  a_word_drive: assert property (
    @(posedge i_link_clk) disable iff (i_rst)
    i_codec_frame_sync_in |=> s_drive16)
    else $error("word not driven");
  a_word_end: assert property (
    @(posedge i_link_clk) disable iff (i_rst)
    i_codec_frame_sync_in ##1 s_quiet16 |=> o_codec_serial_data_out_oe_n)
    else $error("pin still driven after word");
  a_adc_take: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_adc_valid && o_adc_ready |=> (!o_adc_ready)[*8])
    else $error("ready not held low after take");
  a_adc_back: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_adc_ready) |-> ##[1:400] o_adc_ready)
    else $error("ready lost");
  a_play_hold: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_play_valid && !i_play_ready |=> o_play_valid && $stable(o_play_word))
    else $error("play word changed while stalled");
  a_ovr_pulse: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_play_overrun |=> !o_play_overrun)
    else $error("overrun too long");
  a_ovr_full: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_play_overrun |-> o_play_valid)
    else $error("overrun with buffer empty");
  a_vol_pop: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !$stable(o_play_volume) |-> pop_q)
    else $error("volume moved without pop");
endmodule : pcl_link_checker
bind pcl_codec_link pcl_link_checker pcl_link_checker_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
  .i_codec_frame_sync_in(i_codec_frame_sync_in),
  .o_codec_serial_data_out_oe_n(o_codec_serial_data_out_oe_n),
  .i_adc_valid(i_adc_valid), .o_adc_ready(o_adc_ready),
  .o_play_valid(o_play_valid), .i_play_ready(i_play_ready),
  .o_play_word(o_play_word), .o_play_volume(o_play_volume),
  .o_play_overrun(o_play_overrun));
`default_nettype wire

// file: testbench/pcl_master_model.sv
// Purpose: serial port master facing the codec
// Assumes: codec samples and drives on the rising edge
// Notes: frame length is a parameter
`timescale 1ns/10ps
`default_nettype none
`include "pcl_consts.svh"
module pcl_master_model #(
  parameter int FRAME_BITS = 256
) (
  input wire logic [`PCL_WORD_BITS-1:0] i_tx_word,
  input wire logic i_data_from_codec,
  output logic o_link_clk,
  output logic o_frame_sync,
  output logic o_data_to_codec,
  output logic [`PCL_WORD_BITS-1:0] o_rx_word,
  output int o_frames
);
  int bit_n = 20;
  initial
  begin
    o_link_clk = 1'h0;
    o_frame_sync = 1'h0;
    o_data_to_codec = 1'h0;
    o_rx_word = 16'h0000;
    o_frames = 0;
  end
  // free-running bit clock
  // odd start offset keeps its edges off the system clock's edges
  initial
  begin
    #3.33;
    forever #62.5 o_link_clk = ~o_link_clk;
  end
  // one msb-first word per frame, idle bits toggle
  always @(negedge o_link_clk)
  begin
    o_frame_sync <= (bit_n == 0);
    o_data_to_codec <= bit_n < 16 ? i_tx_word[15-bit_n] : ~o_data_to_codec;
    if (bit_n >= 1 && bit_n <= 16)
      o_rx_word <= {o_rx_word[14:0], i_data_from_codec};
    if (bit_n == 16)
      o_frames <= o_frames + 1;
    bit_n <= (bit_n + 1) % FRAME_BITS;
  end
endmodule : pcl_master_model
`default_nettype wire

// file: testbench/tb_pcl_codec_serial_link.sv
// Purpose: self-checking bench of the codec link
// Assumes: master model makes clock and sync
// Notes: short frames keep the run brief
`timescale 1ns/10ps
`default_nettype none
`include "pcl_consts.svh"
module tb_pcl_codec_serial_link;
  logic clk = 1'h0, rst = 1'h1, lin = 1'h1, av = 1'h0, pr = 1'h1;
  logic [12:0] as = 13'h0000;
  logic [15:0] tx = 16'h0000, rx, pw, w, e;
  logic lclk, sync, din, dout, oe_n, ar, pv, ovr;
  logic [2:0] vol, vol_e;
  int frames, error_cnt = 0, total_checks = 0, cyc = 0, ovr_n;
  logic [15:0] q[$];
  bit chk = 0, vk = 0;
  pcl_codec_link pcl_codec_link_inst (.i_sys_clk(clk), .i_rst(rst),
    .i_link_clk(lclk), .i_codec_frame_sync_in(sync),
    .i_codec_serial_data_in(din), .o_codec_serial_data_out(dout),
    .o_codec_serial_data_out_oe_n(oe_n), .i_linear_mode(lin),
    .i_adc_valid(av), .o_adc_ready(ar), .i_adc_sample(as),
    .o_play_valid(pv), .i_play_ready(pr), .o_play_word(pw),
    .o_play_volume(vol), .o_play_overrun(ovr));
  pcl_master_model #(.FRAME_BITS(40)) pcl_master_model_inst (
    // a released pin shows the inverse, so an early release is caught
    .i_tx_word(tx), .i_data_from_codec(oe_n ? ~dout : dout),
    .o_link_clk(lclk),
    .o_frame_sync(sync), .o_data_to_codec(din), .o_rx_word(rx),
    .o_frames(frames));
  always #2 clk = ~clk;
  task automatic cmp(input string n, input logic [15:0] x,
    input logic [15:0] s);
    total_checks++;
    if (x !== s)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : cmp
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic wait_frame();
    int f;
    f = frames;
    wait (frames != f);
    @(posedge clk);
  endtask : wait_frame
  always @(posedge clk)
  begin
    cyc++;
    if (chk && vk)
      cmp("volume", 16'(vol_e), 16'(vol));
    if (chk && ovr)
    begin
      ovr_n++;
      w = q.pop_back();
    end
    if (chk && pv && pr)
    begin
      w = q.pop_front();
      cmp("play word", w, pw);
      vk = vk | lin;
      vol_e = lin ? w[2:0] : vol_e;
    end
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("[FAIL] cycles expected below %0d seen %0d", 40000, cyc);
      print_verdict();
    end
  end
  task automatic phase(input logic l);
    chk = 0;
    rst <= 1'h1;
    lin <= l;
    repeat (12) @(posedge clk);
    repeat (2) @(posedge lclk);
    wait_frame();
    rst <= 1'h0;
    vol_e = 3'h0;
    vk = !l;
    ovr_n = 0;
    q.delete();
    wait_frame();
    for (int i = 0; i < 7; i++)
    begin
      // words of the last three frames find the buffer stalled
      pr <= (i < 4);
      tx = 16'($urandom());
      q.push_back(tx);
      chk = 1;
      as <= 13'($urandom());
      av <= 1'h1;
      do @(posedge clk); while (ar !== 1'h1);
      av <= 1'h0;
      e = l ? {as, 3'h0} : {as[7:0], 8'h00};
      wait_frame();
      cmp("sample word", e, rx);
    end
    pr <= 1'h1;
    repeat (20) @(posedge clk);
    cmp("words left", 16'h0000, 16'(q.size()));
    cmp("overruns", 16'h0001, 16'(ovr_n));
  endtask : phase
  initial
  begin
    void'($urandom(32'hB7AE));
    phase(1'h1);
    phase(1'h0);
    print_verdict();
  end
endmodule : tb_pcl_codec_serial_link
`default_nettype wire
